// file: rtl/dwd_config_regs.sv
`timescale 1ns/1ps
// How it works
// - window top row register at 05h, reset 06.
// - window bottom row register at 06h, reset 06.
// - 10-bit row active count from 07h and 08h bits 1-0.
// - each row active for twice the count in lines, black otherwise.
// - count zero or above 527 gives full-frame duty.
// - in 3D, 08h bit 4 picks duty range on non-enabled frames.
// - 09h bit 5 enables ramp monitor, bit 3 forces DAC high.
// - 09h bit 2 picks ramp return time, 500 ns or 150 ns.
// - 09h bits 1-0 shift ramp start half clock early, none, late.
// - 0Ah holds buffer and amp bias nibbles, 0100 nominal, 0000 off.
// - 0Bh ramp DAC ceiling, reset 80h.
// - 0Ch bits 2-0 pixel sink current, reset 1.
// - 0Dh bit 4 holds pump off during sensor sampling.
// - 0Dh bit 3 enables sensor sample-and-hold.
// - 0Dh bits 2-0 sensor current step, reference over two to seven-minus-code.
// - 0Eh bits 3-2 enable overcurrent sensing; overcurrent stops pump drive.
// - 0Eh bits 1-0 choose regulated, clamped or manual converter mode.
// - clamped mode limits at level register; manual holds fixed level.
// - dimming level acts only in mode one.
// - write protect bit makes other registers ignore writes.
module dwd_config_regs
  import dwd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port from serial slave
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // protect bit from input-mode register
  input wire logic write_protect,
  // video timing
  input wire logic frame_start,
  input wire logic line_start,
  input wire logic mode_3d,
  input wire logic frame_enabled,
  input wire logic ramp_start,
  input wire logic sensor_sampling,
  // cathode loop inputs
  input wire logic overcurrent_detect,
  input wire logic supply_above_level,
  input wire logic [7:0] cathode_supply_level,
  input wire logic [6:0] dimming_level,
  // window and duty
  output logic [7:0] window_top_row,
  output logic [7:0] window_bottom_row,
  output logic row_black,
  // ramp
  output logic ramp_monitor_enable,
  output logic ramp_dac_force_high,
  output logic ramp_flyback,
  output logic ramp_early,
  output logic ramp_late,
  output logic [3:0] ramp_buffer_bias,
  output logic [3:0] ramp_amp_bias,
  output logic [7:0] ramp_dac_ceiling,
  // pixel and sensor
  output logic [2:0] pixel_sink_current,
  output logic external_reference_select,
  output logic sensor_sample_hold_enable,
  output logic [7:0] sensor_current_div,
  // cathode converter
  output logic pump_drive_output,
  output logic [1:0] cathode_regulation_mode,
  output logic [7:0] cathode_target_level,
  output logic [6:0] dimming_effective
);
  // decoded write enables
  logic wr_ok;
  logic wr_top;
  logic wr_bot;
  logic wr_rowl;
  logic wr_rowh;
  logic wr_ramp;
  logic wr_bias;
  logic wr_dacmx;
  logic wr_pix;
  logic wr_gamma;
  logic wr_cath;
  // register values
  logic [7:0] top_v;
  logic [7:0] bot_v;
  logic [7:0] rowl_v;
  logic [7:0] rowh_v;
  logic [7:0] ramp_v;
  logic [7:0] bias_v;
  logic [7:0] dacmx_v;
  logic [7:0] pix_v;
  logic [7:0] gamma_v;
  logic [7:0] cath_v;
  logic [7:0] rdata_nxt;
  // pump trip and ramp return timer
  logic trip_r;
  logic trip_nxt;
  logic [7:0] flyb_cnt_r;
  logic [7:0] flyb_cnt_nxt;
  // packed decoded outputs
  logic [19:0] out_nxt;
  logic [19:0] out_r;
  logic [7:0] level_nxt;
  logic [6:0] dim_nxt;
  logic drive_nxt;
  // packed outputs as they follow from the register reset values
  localparam logic [19:0] OUT_RST = {RST_RAMP[RAMP_MON_BIT], RST_RAMP[RAMP_HIGH_BIT], 1'b0,
    (RST_RAMP[1:0] == 2'b00), (RST_RAMP[1:0] == 2'b10), RST_BIAS, RST_PIX[2:0], RST_PIX[3],
    RST_GAMMA[GAMMA_SH_BIT], RST_CATH[1:0]};

  assign wr_ok = reg_wr && !write_protect;

  function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
    sel = (a == off);
  endfunction : sel

  // one enable per mapped offset; unmapped writes match none
  always_comb begin
    wr_top = wr_ok && sel(reg_addr, OFF_TOP);
    wr_bot = wr_ok && sel(reg_addr, OFF_BOT);
    wr_rowl = wr_ok && sel(reg_addr, OFF_ROWL);
    wr_rowh = wr_ok && sel(reg_addr, OFF_ROWH);
    wr_ramp = wr_ok && sel(reg_addr, OFF_RAMP);
    wr_bias = wr_ok && sel(reg_addr, OFF_BIAS);
    wr_dacmx = wr_ok && sel(reg_addr, OFF_DACMX);
    wr_pix = wr_ok && sel(reg_addr, OFF_PIX);
    wr_gamma = wr_ok && sel(reg_addr, OFF_GAMMA);
    wr_cath = wr_ok && sel(reg_addr, OFF_CATH);
  end

  // register cells
  dwd_reg_cell #(.RESET_VAL(RST_TOP), .WR_MASK(8'hff)) u_top (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_top),
    .wr_data(reg_wdata),
    .value(top_v)
  );
  dwd_reg_cell #(.RESET_VAL(RST_BOT), .WR_MASK(8'hff)) u_bot (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_bot),
    .wr_data(reg_wdata),
    .value(bot_v)
  );
  dwd_reg_cell #(.RESET_VAL(RST_ROWL), .WR_MASK(8'hff)) u_rowl (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_rowl),
    .wr_data(reg_wdata),
    .value(rowl_v)
  );
  dwd_reg_cell #(.RESET_VAL(RST_ROWH), .WR_MASK(MSK_ROWH)) u_rowh (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_rowh),
    .wr_data(reg_wdata),
    .value(rowh_v)
  );
  dwd_reg_cell #(.RESET_VAL(RST_RAMP), .WR_MASK(MSK_RAMP)) u_ramp (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_ramp),
    .wr_data(reg_wdata),
    .value(ramp_v)
  );
  dwd_reg_cell #(.RESET_VAL(RST_BIAS), .WR_MASK(8'hff)) u_bias (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_bias),
    .wr_data(reg_wdata),
    .value(bias_v)
  );
  dwd_reg_cell #(.RESET_VAL(RST_DACMX), .WR_MASK(8'hff)) u_dacmx (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_dacmx),
    .wr_data(reg_wdata),
    .value(dacmx_v)
  );
  dwd_reg_cell #(.RESET_VAL(RST_PIX), .WR_MASK(MSK_PIX)) u_pix (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_pix),
    .wr_data(reg_wdata),
    .value(pix_v)
  );
  dwd_reg_cell #(.RESET_VAL(RST_GAMMA), .WR_MASK(MSK_GAMMA)) u_gamma (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_gamma),
    .wr_data(reg_wdata),
    .value(gamma_v)
  );
  dwd_reg_cell #(.RESET_VAL(RST_CATH), .WR_MASK(MSK_CATH)) u_cath (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(wr_cath),
    .wr_data(reg_wdata),
    .value(cath_v)
  );

  dwd_row_duty #(.LINE_W(11)) u_duty (
    .ref_clk(ref_clk),
    .rst(rst),
    .frame_start(frame_start),
    .line_start(line_start),
    .row_active_count({rowh_v[1:0], rowl_v}),
    .mode_3d(mode_3d),
    .frame_enabled(frame_enabled),
    .unenabled_high_range(rowh_v[ROWH_3D_BIT]),
    .row_black(row_black)
  );

  // read mux, registered
  always_comb begin
    unique case (reg_addr)
      OFF_TOP: rdata_nxt = top_v;
      OFF_BOT: rdata_nxt = bot_v;
      OFF_ROWL: rdata_nxt = rowl_v;
      OFF_ROWH: rdata_nxt = rowh_v;
      OFF_RAMP: rdata_nxt = ramp_v;
      OFF_BIAS: rdata_nxt = bias_v;
      OFF_DACMX: rdata_nxt = dacmx_v;
      OFF_PIX: rdata_nxt = pix_v;
      OFF_GAMMA: rdata_nxt = gamma_v;
      OFF_CATH: rdata_nxt = cath_v;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // ramp return timer: one pulse per ramp start
  always_comb begin
    flyb_cnt_nxt = flyb_cnt_r;
    if (ramp_start) begin
      flyb_cnt_nxt = ramp_v[RAMP_FLYB_BIT] ? FLYB_SHORT_CYC : FLYB_LONG_CYC;
    end else if (flyb_cnt_r != 8'h00) begin
      flyb_cnt_nxt = flyb_cnt_r - 8'h01;
    end
  end

  // overcurrent trip latches until sensing disabled
  always_comb begin
    trip_nxt = trip_r;
    if (cath_v[3:2] == 2'b00) trip_nxt = 1'b0;
    else if (overcurrent_detect) trip_nxt = 1'b1;
  end

  always_comb begin
    drive_nxt = !trip_nxt;
    if (gamma_v[GAMMA_PUMP_BIT] && sensor_sampling) drive_nxt = 1'b0;
    unique case (cath_v[1:0])
      MODE_CLAMP: level_nxt = supply_above_level ? cathode_supply_level : 8'h00;
      MODE_MANUAL: level_nxt = cathode_supply_level;
      default: level_nxt = 8'h00;
    endcase
    dim_nxt = (cath_v[1:0] == MODE_ONE) ? dimming_level : 7'h00;
    out_nxt = {ramp_v[RAMP_MON_BIT], ramp_v[RAMP_HIGH_BIT], (flyb_cnt_nxt != 8'h00),
               (ramp_v[1:0] == 2'b00), (ramp_v[1:0] == 2'b10),
               bias_v,
               pix_v[2:0], pix_v[3], gamma_v[GAMMA_SH_BIT],
               cath_v[1:0]};
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      trip_r <= 1'b0;
      flyb_cnt_r <= 8'h00;
      out_r <= OUT_RST;
      window_top_row <= RST_TOP;
      window_bottom_row <= RST_BOT;
      ramp_dac_ceiling <= RST_DACMX;
      sensor_current_div <= 8'h80;
      pump_drive_output <= 1'b0;
      cathode_target_level <= 8'h00;
      dimming_effective <= 7'h00;
    end else begin
      reg_rdata <= rdata_nxt;
      trip_r <= trip_nxt;
      flyb_cnt_r <= flyb_cnt_nxt;
      out_r <= out_nxt;
      window_top_row <= top_v;
      window_bottom_row <= bot_v;
      ramp_dac_ceiling <= dacmx_v;
      sensor_current_div <= 8'h80 >> gamma_v[2:0];
      pump_drive_output <= drive_nxt;
      cathode_target_level <= level_nxt;
      dimming_effective <= dim_nxt;
    end
  end

  assign ramp_monitor_enable = out_r[19];
  assign ramp_dac_force_high = out_r[18];
  assign ramp_flyback = out_r[17];
  assign ramp_early = out_r[16];
  assign ramp_late = out_r[15];
  assign ramp_buffer_bias = out_r[14:11];
  assign ramp_amp_bias = out_r[10:7];
  assign pixel_sink_current = out_r[6:4];
  assign external_reference_select = out_r[3];
  assign sensor_sample_hold_enable = out_r[2];
  assign cathode_regulation_mode = out_r[1:0];
endmodule : dwd_config_regs

// file: rtl/dwd_pkg.sv
package dwd_pkg;
  // register offsets
  localparam logic [7:0] OFF_TOP = 8'h05;
  localparam logic [7:0] OFF_BOT = 8'h06;
  localparam logic [7:0] OFF_ROWL = 8'h07;
  localparam logic [7:0] OFF_ROWH = 8'h08;
  localparam logic [7:0] OFF_RAMP = 8'h09;
  localparam logic [7:0] OFF_BIAS = 8'h0a;
  localparam logic [7:0] OFF_DACMX = 8'h0b;
  localparam logic [7:0] OFF_PIX = 8'h0c;
  localparam logic [7:0] OFF_GAMMA = 8'h0d;
  localparam logic [7:0] OFF_CATH = 8'h0e;
  localparam logic [7:0] OFF_INMODE = 8'h01;
  // reset values
  localparam logic [7:0] RST_TOP = 8'h06;
  localparam logic [7:0] RST_BOT = 8'h06;
  localparam logic [7:0] RST_ROWL = 8'h00;
  localparam logic [7:0] RST_ROWH = 8'h00;
  localparam logic [7:0] RST_RAMP = 8'h01;
  localparam logic [7:0] RST_BIAS = 8'h44;
  localparam logic [7:0] RST_DACMX = 8'h80;
  localparam logic [7:0] RST_PIX = 8'h01;
  localparam logic [7:0] RST_GAMMA = 8'h00;
  localparam logic [7:0] RST_CATH = 8'h04;
  // writable bit masks; other bits hold reset value
  localparam logic [7:0] MSK_ROWH = 8'h13;
  localparam logic [7:0] MSK_RAMP = 8'h2f;
  localparam logic [7:0] MSK_PIX = 8'h0f;
  localparam logic [7:0] MSK_GAMMA = 8'h1f;
  localparam logic [7:0] MSK_CATH = 8'h0f;
  // field positions
  localparam int ROWH_3D_BIT = 4;
  localparam int RAMP_MON_BIT = 5;
  localparam int RAMP_HIGH_BIT = 3;
  localparam int RAMP_FLYB_BIT = 2;
  localparam int GAMMA_PUMP_BIT = 4;
  localparam int GAMMA_SH_BIT = 3;
  localparam int PROTECT_BIT = 7;
  // row duty limits
  localparam logic [9:0] ROW_COUNT_MAX = 10'd527;
  // ramp return times
  localparam int CLK_MHZ = 100;
  localparam int FLYB_LONG_NS = 500;
  localparam int FLYB_SHORT_NS = 150;
  localparam logic [7:0] FLYB_LONG_CYC = 8'((FLYB_LONG_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] FLYB_SHORT_CYC = 8'((FLYB_SHORT_NS * CLK_MHZ + 999) / 1000);
  // cathode converter modes
  localparam logic [1:0] MODE_ONE = 2'h0;
  localparam logic [1:0] MODE_CLAMP = 2'h1;
  localparam logic [1:0] MODE_MANUAL = 2'h2;
  typedef enum logic [1:0] {DWD_PH_ACTIVE, DWD_PH_BLACK} dwd_phase_e;
endpackage : dwd_pkg

// file: rtl/dwd_reg_cell.sv
`timescale 1ns/1ps
// one 8-bit register with write mask
module dwd_reg_cell #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hff
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // write side
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // value
  output logic [7:0] value
);
  logic [7:0] value_nxt;

  always_comb begin
    value_nxt = value;
    if (wr_en) begin
      value_nxt = (wr_data & WR_MASK) | (RESET_VAL & ~WR_MASK);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      value <= RESET_VAL;
    end else begin
      value <= value_nxt;
    end
  end
endmodule : dwd_reg_cell

// file: rtl/dwd_row_duty.sv
`timescale 1ns/1ps
// per-row active/black decision from line position in frame
module dwd_row_duty
  import dwd_pkg::*;
#(
  parameter int LINE_W = 11
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // timing
  input wire logic frame_start,
  input wire logic line_start,
  // settings
  input wire logic [9:0] row_active_count,
  input wire logic mode_3d,
  input wire logic frame_enabled,
  input wire logic unenabled_high_range,
  // result
  output logic row_black
);
  // counter must hold twice the 10-bit count and reach the half-frame bit
  if (LINE_W < 11) begin : g_width_check
    $error("line counter too narrow");
  end

  logic [LINE_W-1:0] line_r, line_nxt;
  logic black_nxt;
  logic [LINE_W-1:0] limit;
  logic full;

  always_comb begin
    line_nxt = line_r;
    if (frame_start) line_nxt = '0;
    else if (line_start) line_nxt = line_r + 1'b1;
    limit = LINE_W'({row_active_count, 1'b0});
    full = (row_active_count == 10'd0) || (row_active_count > ROW_COUNT_MAX);
    black_nxt = !full && (line_nxt >= limit);
    if (mode_3d && !frame_enabled) begin
      // non-enabled frame: high range keeps first half lit, low range limits to first half
      if (unenabled_high_range) black_nxt = !full && (line_nxt >= limit) && line_nxt[LINE_W-1];
      else black_nxt = !full && ((line_nxt >= limit) || line_nxt[LINE_W-1]);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_r <= '0;
      row_black <= 1'b0;
    end else begin
      line_r <= line_nxt;
      row_black <= black_nxt;
    end
  end
endmodule : dwd_row_duty

// file: sim/dwd_host_model.sv
`timescale 1ns/1ps
// host side of the register port; drives on the falling edge
module dwd_host_model
  import dwd_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // register port
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one-cycle write, then an idle cycle with scrambled data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = (a == OFF_PIX) ? (d & 8'hf7) : d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    reg_addr = a;
    @(negedge ref_clk);
  endtask : rd
endmodule : dwd_host_model

// file: sim/dwd_cfg_asserts.sv
`timescale 1ns/1ps
module dwd_cfg_asserts
  import dwd_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic write_protect,
  // outputs watched
  input wire logic [7:0] window_top_row,
  input wire logic [7:0] window_bottom_row,
  input wire logic [7:0] ramp_dac_ceiling,
  input wire logic [3:0] ramp_buffer_bias,
  input wire logic [3:0] ramp_amp_bias,
  input wire logic ramp_monitor_enable,
  input wire logic ramp_dac_force_high,
  input wire logic ramp_early,
  input wire logic ramp_late,
  input wire logic ramp_flyback,
  input wire logic [2:0] pixel_sink_current,
  input wire logic external_reference_select,
  input wire logic sensor_sample_hold_enable,
  input wire logic [7:0] sensor_current_div,
  input wire logic [1:0] cathode_regulation_mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] fly_cnt_r;
  logic [7:0] fly_cnt_nxt;
  always_comb begin
    fly_cnt_nxt = ramp_flyback ? fly_cnt_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fly_cnt_r <= 8'h00;
    end else begin
      fly_cnt_r <= fly_cnt_nxt;
    end
  end
  // accepted write followed by an idle cycle
  sequence s_take(logic [7:0] a);
    reg_wr && !write_protect && reg_addr == a ##1 !reg_wr;
  endsequence
  property p_byte(logic [7:0] a, logic [7:0] o);
    s_take(a) |=> o == $past(reg_wdata, 2);
  endproperty
  a_top_row_load: assert property (p_byte(OFF_TOP, window_top_row)) else $error("top row not loaded");
  a_bottom_row_load: assert property (p_byte(OFF_BOT, window_bottom_row)) else $error("bottom row bad");
  a_ceiling_load: assert property (p_byte(OFF_DACMX, ramp_dac_ceiling)) else $error("ceiling bad");
  a_bias_load: assert property (p_byte(OFF_BIAS, {ramp_buffer_bias, ramp_amp_bias})) else $error("bias bad");
  a_ramp_fields: assert property (s_take(OFF_RAMP) |=> ramp_monitor_enable == $past(reg_wdata[5], 2)
    && ramp_dac_force_high == $past(reg_wdata[3], 2) && ramp_early == ($past(reg_wdata[1:0], 2) == 2'b00)
    && ramp_late == ($past(reg_wdata[1:0], 2) == 2'b10)) else $error("ramp fields bad");
  a_pixel_fields: assert property (s_take(OFF_PIX) |=> pixel_sink_current == $past(reg_wdata[2:0], 2)
    && external_reference_select == $past(reg_wdata[3], 2)) else $error("pixel fields bad");
  a_sensor_step: assert property (s_take(OFF_GAMMA) |=> sensor_current_div == (8'h80 >> $past(reg_wdata[2:0], 2))
    && sensor_sample_hold_enable == $past(reg_wdata[3], 2)) else $error("sensor fields bad");
  a_mode_load: assert property (s_take(OFF_CATH) |=> cathode_regulation_mode == $past(reg_wdata[1:0], 2))
    else $error("mode bad");
  a_flyback_len: assert property ($fell(ramp_flyback) |-> fly_cnt_r == FLYB_LONG_CYC || fly_cnt_r == FLYB_SHORT_CYC)
    else $error("flyback length bad");
  a_protect_hold: assert property (write_protect [*3] |-> $stable(window_top_row) && $stable(ramp_dac_ceiling)
    && $stable(cathode_regulation_mode)) else $error("write under protect");
endmodule : dwd_cfg_asserts
bind dwd_config_regs dwd_cfg_asserts u_chk (.*);

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import dwd_pkg::*;
;
  logic ref_clk, rst, write_protect, frame_start, line_start, mode_3d, frame_enabled, ramp_start;
  logic sensor_sampling, overcurrent_detect, supply_above_level, reg_wr, row_black;
  logic [7:0] cathode_supply_level, reg_addr, reg_wdata, reg_rdata, window_top_row, window_bottom_row;
  logic [7:0] ramp_dac_ceiling, sensor_current_div, cathode_target_level;
  logic [6:0] dimming_level, dimming_effective;
  logic ramp_monitor_enable, ramp_dac_force_high, ramp_flyback, ramp_early, ramp_late;
  logic [3:0] ramp_buffer_bias, ramp_amp_bias;
  logic [2:0] pixel_sink_current;
  logic external_reference_select, sensor_sample_hold_enable, pump_drive_output;
  logic [1:0] cathode_regulation_mode;
  int miscompares = 0;
  int tests_run = 0;
  logic [7:0] offs [10] = '{OFF_TOP, OFF_BOT, OFF_ROWL, OFF_ROWH, OFF_RAMP, OFF_BIAS, OFF_DACMX, OFF_PIX, OFF_GAMMA,
    OFF_CATH};
  logic [7:0] rsts [10] = '{RST_TOP, RST_BOT, RST_ROWL, RST_ROWH, RST_RAMP, RST_BIAS, RST_DACMX, RST_PIX, RST_GAMMA,
    RST_CATH};
  logic [7:0] msks [10] = '{8'hff, 8'hff, 8'hff, MSK_ROWH, MSK_RAMP, 8'hff, 8'hff, MSK_PIX, MSK_GAMMA, MSK_CATH};
  dwd_config_regs uut (.*);
  dwd_host_model host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic settle;
    repeat (2) @(negedge ref_clk);
  endtask : settle
  task automatic conclude;
    $display("compares=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic t_regs;
    logic [7:0] v;
    for (int i = 0; i < 10; i++) begin
      host.rd(offs[i]);
      check(reg_rdata, rsts[i]);
    end
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'h00 : 8'hff;
      for (int i = 0; i < 10; i++) begin
        host.wr(offs[i], v);
        host.rd(offs[i]);
        check(reg_rdata, (v & msks[i] & ((offs[i] == OFF_PIX) ? 8'hf7 : 8'hff)) | (rsts[i] & ~msks[i]));
      end
    end
    host.wr(8'h20, 8'h5a);
    host.rd(8'h20);
    check(reg_rdata, 8'h00);
    @(negedge ref_clk);
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    host.rd(OFF_DACMX);
    check(reg_rdata, RST_DACMX);
  endtask : t_regs
  task automatic t_window_protect;
    host.wr(OFF_TOP, 8'h09);
    host.wr(OFF_BOT, 8'h03);
    settle();
    check(window_top_row, 8'h09);
    check(window_bottom_row, 8'h03);
    write_protect = 1'b1;
    host.wr(OFF_DACMX, 8'h12);
    settle();
    host.rd(OFF_DACMX);
    check(reg_rdata, 8'h80);
    check(ramp_dac_ceiling, 8'h80);
    write_protect = 1'b0;
    host.wr(OFF_DACMX, 8'h12);
    settle();
    check(ramp_dac_ceiling, 8'h12);
  endtask : t_window_protect
  task automatic t_ramp;
    int n;
    for (int c = 0; c < 3; c++) begin
      host.wr(OFF_RAMP, 8'(c));
      settle();
      check({ramp_late, ramp_early}, (c == 0) ? 8'h01 : (c == 2) ? 8'h02 : 8'h00);
    end
    for (int b = 0; b < 2; b++) begin
      host.wr(OFF_RAMP, b ? 8'h05 : 8'h01);
      settle();
      ramp_start = 1'b1;
      @(negedge ref_clk);
      ramp_start = 1'b0;
      n = 0;
      repeat (80) begin
        n += ramp_flyback;
        @(negedge ref_clk);
      end
      check(8'(n), b ? 8'd15 : 8'd50);
    end
  endtask : t_ramp
  task automatic t_sensor_pump;
    for (int c = 0; c < 8; c++) begin
      host.wr(OFF_GAMMA, 8'(c));
      settle();
      check(sensor_current_div, 8'h80 >> c);
    end
    host.wr(OFF_GAMMA, 8'h18);
    // sensor settle wait belongs to the host and is far longer than this run
    sensor_sampling = 1'b1;
    settle();
    check(pump_drive_output, 8'h00);
    check(sensor_sample_hold_enable, 8'h01);
    host.wr(OFF_GAMMA, 8'h00);
    settle();
    check(pump_drive_output, 8'h01);
    sensor_sampling = 1'b0;
    for (int k = 0; k < 2; k++) begin
      overcurrent_detect = 1'b1;
      settle();
      overcurrent_detect = 1'b0;
      settle();
      check(pump_drive_output, 8'(k));
      host.wr(OFF_CATH, 8'h00);
      settle();
    end
  endtask : t_sensor_pump
  task automatic t_modes;
    for (int m = 0; m < 3; m++) begin
      supply_above_level = 1'b1;
      host.wr(OFF_CATH, 8'(m));
      settle();
      check(cathode_regulation_mode, 8'(m));
      check(dimming_effective, (m == 0) ? 8'h64 : 8'h00);
      if (m > 0) check(cathode_target_level, 8'h51);
      supply_above_level = (m == 2);
      settle();
      if (m == 1) check(cathode_target_level, 8'h00);
    end
  endtask : t_modes
  task automatic t_duty(input logic [9:0] cnt, input int exp);
    int nb;
    host.wr(OFF_ROWL, cnt[7:0]);
    host.wr(OFF_ROWH, {6'h00, cnt[9:8]});
    settle();
    nb = 0;
    frame_start = 1'b1;
    for (int l = 0; l < 20; l++) begin
      line_start = 1'b1;
      @(negedge ref_clk);
      frame_start = 1'b0;
      line_start = 1'b0;
      repeat (4) @(negedge ref_clk);
      nb += row_black;
      repeat (3) @(negedge ref_clk);
    end
    check(8'(nb), 8'(exp));
  endtask : t_duty
  task automatic t_duty_3d(input logic [9:0] cnt, input logic hi, input int exp);
    int nb;
    host.wr(OFF_ROWL, cnt[7:0]);
    host.wr(OFF_ROWH, {3'h0, hi, 2'h0, cnt[9:8]});
    mode_3d = 1'b1;
    frame_enabled = 1'b0;
    settle();
    nb = 0;
    frame_start = 1'b1;
    line_start = 1'b1;
    @(negedge ref_clk);
    frame_start = 1'b0;
    repeat (1040) begin
      nb += row_black;
      @(negedge ref_clk);
    end
    line_start = 1'b0;
    mode_3d = 1'b0;
    frame_enabled = 1'b1;
    check(8'(nb), 8'(exp));
  endtask : t_duty_3d
  initial begin
    {rst, write_protect, frame_start, line_start, mode_3d, ramp_start, sensor_sampling} = 7'h40;
    {overcurrent_detect, supply_above_level, frame_enabled} = 3'b011;
    cathode_supply_level = 8'h51;
    dimming_level = 7'h64;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    t_regs();
    t_window_protect();
    t_ramp();
    t_sensor_pump();
    t_modes();
    t_duty(10'd2, 16);
    t_duty(10'd0, 0);
    t_duty(10'd600, 0);
    t_duty_3d(10'd520, 1'b0, 16);
    t_duty_3d(10'd2, 1'b1, 16);
    conclude();
  end
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
endmodule : tb_top
